// ### pkg/scs_pkg.sv
package scs_pkg;

   // Register byte offsets on the APB side
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] SPREAD_OFS = 8'h08;
   localparam logic [7:0] PROFILE_OFS = 8'h0C;

   // Control field positions and values after reset
   localparam int CTRL_OUT_EN_BIT = 0;
   localparam int CTRL_MOD_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   // Strap defaults follow the internal pull-ups
   localparam logic [1:0] RATE_STRAP_RESET = 2'h3;
   localparam logic [2:0] MULT_SEL_RESET = 3'h7;
   localparam logic [3:0] SPREAD_CODE_OFF = 4'hF;

   // Strap settle time before the one-time capture
   localparam int CLK_MHZ = 100;
   localparam int STRAP_SETTLE_NS = 1000;
   localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;

   // Modulation profile length in reference periods
   localparam int MOD_DIV_DEFAULT = 512;

   // Deviation unit is 0.125 %, so unity ratio is 800 units
   localparam logic [9:0] RATIO_UNITY = 10'h320;

   typedef enum logic [1:0] {
      SCS_SPREAD_OFF = 2'b00,
      SCS_SPREAD_CENTER = 2'b01,
      SCS_SPREAD_DOWN = 2'b10,
      SCS_SPREAD_ASYM = 2'b11
   } scs_spread_kind_t;

   typedef enum logic [1:0] {
      SCS_ST_SETTLE = 2'b00,
      SCS_ST_LATCH = 2'b01,
      SCS_ST_RUN = 2'b10
   } scs_state_t;

   typedef struct packed {
      scs_spread_kind_t kind;
      logic [4:0] up;
      logic [4:0] dn;
   } scs_spread_cfg_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } scs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } scs_apb_rsp_t;

endpackage : scs_pkg

// ### logic/scs_clock_select.sv
// Contract
// - Multiplier straps form a binary code 000..111 for a factor 1 to 8.
// - Nominal ratio is reference times factor, with spread applied on top.
// - The two rate straps are captured once after power-up and held.
// - After capture the first shared pin drives the crystal output.
// - After capture the second shared pin drives a reference copy.
// - Output enable low floats every clock output; high drives them while control bit 0 is set.
// - Unconnected selection inputs read as one through pull-ups.
// - Spread code 1111 turns modulation off whatever the rate straps.
// - Rate straps 11 with code n below 15 give centre spread 0.125%*(n+1).
// - Straps 10/0011, 01/0111 and 00/1011 give down spread of 1, 2, 3 %.
// - The modulation profile repeats every 512 reference periods.
`timescale 1ns/1ps
`default_nettype none

module scs_clock_select #(
   parameter int MOD_DIV = scs_pkg::MOD_DIV_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire scs_pkg::scs_apb_req_t apb_req,
   output scs_pkg::scs_apb_rsp_t apb_rsp,
   input wire logic ref_clock_in,
   input wire logic pll_clock_in,
   input wire logic mult_sel_msb,
   input wire logic mult_sel_mid,
   input wire logic mult_sel_lsb,
   input wire logic spread_code_b0,
   input wire logic spread_code_b1,
   input wire logic spread_code_b2,
   input wire logic spread_code_b3,
   input wire logic output_enable,
   input wire logic xtal_drive_strap_pin_i,
   output logic xtal_drive_strap_pin_o,
   output logic xtal_drive_strap_pin_oe,
   input wire logic refout_strap_pin_i,
   output logic refout_strap_pin_o,
   output logic refout_strap_pin_oe,
   output logic synth_clock_out_o,
   output logic synth_clock_out_oe,
   output logic straps_latched,
   output logic [3:0] mult_factor,
   output scs_pkg::scs_spread_cfg_t spread_cfg,
   output logic signed [6:0] spread_dev,
   output logic [15:0] synth_ratio,
   output logic mod_wrap
);
   import scs_pkg::*;

   // Phase counter spans one full profile
   localparam int PH_W = $clog2(MOD_DIV);
   // Shift that scales the half-profile phase up to an 8-bit position
   localparam int TRI_SH = 9 - PH_W;

   // Triangle math assumes a power-of-two profile of at least 4 steps
   if (MOD_DIV < 4 || (1 << PH_W) != MOD_DIV) begin : g_bad_div
      $error("MOD_DIV must be a power of two, 4 or more");
   end

   // A longer profile would need a wider triangle than the 8-bit step
   if (TRI_SH < 0) begin : g_long_div
      $error("MOD_DIV must not exceed 512");
   end

   ////////////////////////////////////////////////////////////////////////
   // Spread selection table
   ////////////////////////////////////////////////////////////////////////

   // Units of 0.125 %; rate straps set a step k of 1..3 off centre
   function automatic scs_spread_cfg_t decode_spread(
      input logic [1:0] rate,
      input logic [3:0] code
   );
      scs_spread_cfg_t cfg;
      logic [4:0] k4;
      logic [4:0] k8;
      cfg = '{kind: SCS_SPREAD_OFF, up: 5'h00, dn: 5'h00};
      k4 = {1'b0, 2'(2'h3 - rate), 2'h0};
      k8 = {2'(2'h3 - rate), 3'h0};
      // Off is tested first so code 1111 wins over every rate
      if (code == SPREAD_CODE_OFF) begin
         cfg.kind = SCS_SPREAD_OFF;
      end else if (rate == RATE_STRAP_RESET) begin
         cfg.kind = SCS_SPREAD_CENTER;
         cfg.up = 5'({1'b0, code} + 5'h01);
         cfg.dn = 5'({1'b0, code} + 5'h01);
      end else if ({1'b0, code} == 5'(k4 - 5'h01)) begin
         cfg.kind = SCS_SPREAD_DOWN;
         cfg.dn = k8;
      end else if ({1'b0, code} >= k4) begin
         cfg.kind = SCS_SPREAD_ASYM;
         cfg.up = 5'({1'b0, code} - k4 + 5'h01);
         cfg.dn = 5'(cfg.up + k8);
      end
      // Unlisted low codes on non-centre straps stay unmodulated
      return cfg;
   endfunction : decode_spread

   ////////////////////////////////////////////////////////////////////////
   // Strap capture sequence
   ////////////////////////////////////////////////////////////////////////

   // Capture sequence state and settle counter
   scs_state_t state_q;
   logic [$clog2(STRAP_SETTLE_CYC + 1)-1:0] settle_q;
   logic [1:0] rate_q;
   logic latched_q;

   // Wait for the pull-ups to settle, then capture once
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SCS_ST_SETTLE;
         settle_q <= '0;
      end else if (clk_en) begin
         unique case (state_q)
            SCS_ST_SETTLE: begin
               if (settle_q == ($bits(settle_q))'(STRAP_SETTLE_CYC - 1)) begin
                  state_q <= SCS_ST_LATCH;
               end else begin
                  settle_q <= settle_q + 1'b1;
               end
            end
            SCS_ST_LATCH: begin
               state_q <= SCS_ST_RUN;
            end
            SCS_ST_RUN: begin
               state_q <= SCS_ST_RUN;
            end
            default: begin
               state_q <= SCS_ST_SETTLE;
            end
         endcase
      end
   end

   // Rate straps default high as if pulled up; captured one time only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_q <= RATE_STRAP_RESET;
         latched_q <= 1'b0;
      end else if (clk_en && state_q == SCS_ST_LATCH) begin
         rate_q <= {refout_strap_pin_i, xtal_drive_strap_pin_i};
         latched_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Static selection decode
   ////////////////////////////////////////////////////////////////////////

   // Decoded straps, re-sampled each cycle as the pins are static
   logic [3:0] factor_q;
   scs_spread_cfg_t cfg_q;
   logic [1:0] ctrl_q;

   // Straps are static, so a plain register is enough to hold them
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         factor_q <= 4'({1'b0, MULT_SEL_RESET} + 4'h1);
         cfg_q <= '{kind: SCS_SPREAD_OFF, up: 5'h00, dn: 5'h00};
      end else if (clk_en) begin
         factor_q <= 4'({1'b0, mult_sel_msb, mult_sel_mid, mult_sel_lsb}
                     + 4'h1);
         cfg_q <= decode_spread(rate_q, {spread_code_b3, spread_code_b2,
                                spread_code_b1, spread_code_b0});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Modulation profile
   ////////////////////////////////////////////////////////////////////////

   // Profile phase, deviation and output ratio
   logic ref_q;
   logic [PH_W-1:0] phase_q;
   logic wrap_q;
   logic mod_on;
   logic ref_rise;
   logic [7:0] tri_pos;
   logic [5:0] span;
   logic [13:0] tri_prod;
   logic signed [6:0] dev_d;
   logic signed [6:0] dev_q;
   logic [15:0] ratio_q;

   // Needs captured straps, the enable bit and a real spread kind
   assign mod_on = latched_q && ctrl_q[CTRL_MOD_EN_BIT]
                   && cfg_q.kind != SCS_SPREAD_OFF;
   // Reference is sampled, so only its rising edge steps the profile
   assign ref_rise = ref_clock_in && !ref_q;

   // Step once per reference period; wrap marks a profile repeat
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_q <= 1'b0;
         phase_q <= '0;
         wrap_q <= 1'b0;
      end else if (clk_en) begin
         ref_q <= ref_clock_in;
         wrap_q <= 1'b0;
         if (!mod_on) begin
            phase_q <= '0;
         end else if (ref_rise) begin
            phase_q <= phase_q + 1'b1;
            wrap_q <= &phase_q;
         end
      end
   end

   // Triangle from -dn up to +up over one half, back over the other
   always_comb begin
      tri_pos = phase_q[PH_W-1] ? ~8'(phase_q[PH_W-2:0] << TRI_SH)
                                : 8'(phase_q[PH_W-2:0] << TRI_SH);
      span = 6'({1'b0, cfg_q.up} + {1'b0, cfg_q.dn});
      tri_prod = 14'(tri_pos * span);
      dev_d = 7'(signed'({1'b0, tri_prod[13:8]}))
              - 7'(signed'({2'b00, cfg_q.dn}));
      if (!mod_on) begin
         dev_d = 7'sh00;
      end
   end

   // Ratio in 1/800 of the reference: factor times (1 + deviation)
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_q <= 7'sh00;
         ratio_q <= 16'h0000;
      end else if (clk_en) begin
         dev_q <= dev_d;
         ratio_q <= 16'(factor_q * 10'(RATIO_UNITY + 10'(dev_d)));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock output pins
   ////////////////////////////////////////////////////////////////////////

   logic drive_en;
   logic xo_q;
   logic xo_oe_q;
   logic ro_q;
   logic ro_oe_q;
   logic so_q;
   logic so_oe_q;

   // Pin enable and register enable both gate the drivers
   assign drive_en = output_enable && ctrl_q[CTRL_OUT_EN_BIT];

   // Shared pins stay inputs until capture so the straps read cleanly
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         xo_q <= 1'b0;
         xo_oe_q <= 1'b0;
         ro_q <= 1'b0;
         ro_oe_q <= 1'b0;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else if (clk_en) begin
         xo_q <= !ref_clock_in;
         xo_oe_q <= latched_q && drive_en;
         ro_q <= ref_clock_in;
         ro_oe_q <= latched_q && drive_en;
         so_q <= pll_clock_in;
         so_oe_q <= drive_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state per access
   ////////////////////////////////////////////////////////////////////////

   // Bus slave state
   logic access;
   logic [31:0] rdata_d;
   logic err_d;
   scs_apb_rsp_t rsp_q;

   // Access phase of a transfer
   assign access = apb_req.psel && apb_req.penable;

   // Read mux; an unmapped offset answers zero with an error
   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      unique case (apb_req.paddr)
         CTRL_OFS: rdata_d = {30'h0, ctrl_q};
         STATUS_OFS: rdata_d = {20'h0, cfg_q.kind, rate_q, factor_q,
                                1'b0, 2'(state_q), latched_q};
         SPREAD_OFS: rdata_d = {9'h0, dev_q, 6'h0, cfg_q.dn,
                                cfg_q.up};
         PROFILE_OFS: rdata_d = {ratio_q, 16'(phase_q)};
         default: err_d = 1'b1;
      endcase
   end

   // Answer registered; pready drops again after each completion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
      end else if (clk_en) begin
         if (access && !rsp_q.pready) begin
            rsp_q.pready <= 1'b1;
            rsp_q.pslverr <= err_d;
            rsp_q.prdata <= apb_req.pwrite ? 32'h0000_0000 : rdata_d;
         end else begin
            rsp_q.pready <= 1'b0;
            rsp_q.pslverr <= 1'b0;
         end
      end
   end

   // Writes land on the edge where the master sees pready high
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (clk_en && access && rsp_q.pready && apb_req.pwrite
                   && apb_req.paddr == CTRL_OFS) begin
         ctrl_q <= apb_req.pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output assignments
   ////////////////////////////////////////////////////////////////////////

   // Every output below is a flip-flop, never a gate
   assign apb_rsp = rsp_q;
   assign xtal_drive_strap_pin_o = xo_q;
   assign xtal_drive_strap_pin_oe = xo_oe_q;
   assign refout_strap_pin_o = ro_q;
   assign refout_strap_pin_oe = ro_oe_q;
   assign synth_clock_out_o = so_q;
   assign synth_clock_out_oe = so_oe_q;
   assign straps_latched = latched_q;
   assign mult_factor = factor_q;
   assign spread_cfg = cfg_q;
   assign spread_dev = dev_q;
   assign synth_ratio = ratio_q;
   assign mod_wrap = wrap_q;

endmodule : scs_clock_select
`default_nettype wire

// ### verification/scs_clock_select_chk.sv
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire scs_pkg::scs_apb_req_t apb_req,
   input wire scs_pkg::scs_apb_rsp_t apb_rsp,
   input wire logic ref_clock_in,
   input wire logic pll_clock_in,
   input wire logic mult_sel_msb,
   input wire logic mult_sel_mid,
   input wire logic mult_sel_lsb,
   input wire logic spread_code_b0,
   input wire logic spread_code_b1,
   input wire logic spread_code_b2,
   input wire logic spread_code_b3,
   input wire logic output_enable,
   input wire logic xtal_drive_strap_pin_o,
   input wire logic xtal_drive_strap_pin_oe,
   input wire logic refout_strap_pin_o,
   input wire logic refout_strap_pin_oe,
   input wire logic synth_clock_out_o,
   input wire logic synth_clock_out_oe,
   input wire logic straps_latched,
   input wire logic [3:0] mult_factor,
   input wire scs_pkg::scs_spread_cfg_t spread_cfg,
   input wire logic signed [6:0] spread_dev
);
   import scs_pkg::*;
   logic [3:0] code;
   logic [2:0] msel;
   // Flattened straps keep the properties short
   assign code = {spread_code_b3, spread_code_b2, spread_code_b1,
                  spread_code_b0};
   assign msel = {mult_sel_msb, mult_sel_mid, mult_sel_lsb};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   a_factor_map: assert property (straps_latched &&
      $past(straps_latched) |-> mult_factor == {1'b0, $past(msel)} + 4'h1)
      else $error("bad factor");
   a_latch_held: assert property (straps_latched |=> straps_latched)
      else $error("capture lost");
   a_pins_idle: assert property (!straps_latched |->
      !xtal_drive_strap_pin_oe && !refout_strap_pin_oe)
      else $error("pin driven before capture");
   a_xtal_drive: assert property (xtal_drive_strap_pin_oe |->
      xtal_drive_strap_pin_o == !$past(ref_clock_in))
      else $error("crystal drive wrong");
   a_refout_copy: assert property (refout_strap_pin_oe |->
      refout_strap_pin_o == $past(ref_clock_in))
      else $error("reference copy wrong");
   a_oe_float: assert property (!output_enable |=> !synth_clock_out_oe)
      else $error("output not floated");
   a_spread_off: assert property ((code == SPREAD_CODE_OFF) [*2] |=>
      spread_cfg.kind == SCS_SPREAD_OFF && spread_dev == 7'sd0)
      else $error("spread not off");
   a_apb_wait: assert property (apb_req.psel && apb_req.penable &&
      !apb_rsp.pready |=> apb_rsp.pready) else $error("no apb answer");
   a_dev_range: assert property (spread_cfg.kind != SCS_SPREAD_OFF &&
      $stable(spread_cfg) |-> spread_dev <= $signed({2'b00, spread_cfg.up})
      && spread_dev >= -$signed({2'b00, spread_cfg.dn}))
      else $error("deviation out of range");
   a_synth_copy: assert property (synth_clock_out_oe |->
      synth_clock_out_o == $past(pll_clock_in))
      else $error("output clock not copied");
endmodule : scs_clock_select_chk
bind scs_clock_select scs_clock_select_chk u_chk (.ref_clk, .rst_n,
   .apb_req, .apb_rsp, .ref_clock_in, .pll_clock_in, .mult_sel_msb,
   .mult_sel_mid, .mult_sel_lsb, .spread_code_b0, .spread_code_b1,
   .spread_code_b2, .spread_code_b3, .output_enable,
   .xtal_drive_strap_pin_o, .xtal_drive_strap_pin_oe, .refout_strap_pin_o,
   .refout_strap_pin_oe, .synth_clock_out_o, .synth_clock_out_oe,
   .straps_latched, .mult_factor, .spread_cfg, .spread_dev);
`default_nettype wire

// ### verification/scs_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_board_model (
   input wire logic ref_clk,
   input wire logic [1:0] pull_lo,
   input wire logic xtal_o,
   input wire logic xtal_oe,
   input wire logic refout_o,
   input wire logic refout_oe,
   output logic ref_clock_in,
   output logic pll_clock_in,
   output logic xtal_i,
   output logic refout_i
);
   logic [1:0] div_q = 2'h0;
   logic pll_q = 1'b0;
   // Reference at a quarter of the system rate, loop clock toggles
   always_ff @(posedge ref_clk) begin
      div_q <= div_q + 2'h1;
      pll_q <= ~pll_q;
   end
   assign ref_clock_in = div_q[1];
   assign pll_clock_in = pll_q;
   // Pull-up wins unless a board resistor pulls low; device drive wins
   assign xtal_i = xtal_oe ? xtal_o : ~pull_lo[0];
   assign refout_i = refout_oe ? refout_o : ~pull_lo[1];
endmodule : scs_board_model
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import scs_pkg::*;
   localparam int DIV = 8;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic oe_in = 1'b1;
   logic [2:0] msel = 3'h7;
   logic [3:0] sc = 4'hF;
   logic [1:0] pull_lo = 2'h0;
   scs_apb_req_t req = '0;
   scs_apb_rsp_t rsp;
   wire logic rclk, pclk, xi, xo, xoe, ri, ro, roe, so, soe, lat, wrap;
   wire logic [3:0] fac;
   wire scs_spread_cfg_t cfg;
   wire logic signed [6:0] dev;
   wire logic [15:0] ratio;
   int num_errors = 0;
   int total_checks = 0;
   logic [31:0] rd;
   logic err;
   initial forever #5 ref_clk = ~ref_clk;
   scs_clock_select #(.MOD_DIV(DIV)) dut (.ref_clk, .rst_n, .clk_en(1'b1),
      .apb_req(req), .apb_rsp(rsp), .ref_clock_in(rclk), .pll_clock_in(pclk),
      .mult_sel_msb(msel[2]), .mult_sel_mid(msel[1]), .mult_sel_lsb(msel[0]),
      .spread_code_b0(sc[0]), .spread_code_b1(sc[1]), .spread_code_b2(sc[2]),
      .spread_code_b3(sc[3]), .output_enable(oe_in),
      .xtal_drive_strap_pin_i(xi), .xtal_drive_strap_pin_o(xo),
      .xtal_drive_strap_pin_oe(xoe), .refout_strap_pin_i(ri),
      .refout_strap_pin_o(ro), .refout_strap_pin_oe(roe),
      .synth_clock_out_o(so), .synth_clock_out_oe(soe), .straps_latched(lat),
      .mult_factor(fac), .spread_cfg(cfg), .spread_dev(dev),
      .synth_ratio(ratio), .mod_wrap(wrap));
   scs_board_model u_board (.ref_clk, .pull_lo, .xtal_o(xo), .xtal_oe(xoe),
      .refout_o(ro), .refout_oe(roe), .ref_clock_in(rclk),
      .pll_clock_in(pclk), .xtal_i(xi), .refout_i(ri));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // Bus cycle held until pready is seen; bounded so a hang ends the run
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge ref_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      if (rsp.pready !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : apb
   ////////////////////////////////////////////////////////////////////////
   // Power-up with the board pulling the shared pins to the given rate
   task automatic boot(input logic [1:0] rate);
      int n;
      pull_lo <= ~rate;
      rst_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (n = 0; n < 200 && lat !== 1'b1; n++) @(posedge ref_clk);
      if (n >= 200) begin
         num_errors++;
         tally_and_finish();
      end
      @(posedge ref_clk);
      chk({xoe, roe}, 2'h3);
      pull_lo <= rate;
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[9:8], rate);
   endtask : boot
   task automatic sp(input logic [3:0] c, input logic [11:0] exp);
      sc <= c;
      repeat (3) @(posedge ref_clk);
      chk(32'(cfg), exp);
   endtask : sp
   task automatic t_factor;
      sc <= SPREAD_CODE_OFF;
      for (int m = 0; m < 8; m++) begin
         msel <= 3'(m);
         repeat (3) @(posedge ref_clk);
         chk(fac, m + 1);
         chk(ratio, 16'((m + 1) * RATIO_UNITY));
      end
   endtask : t_factor
   task automatic t_centre_wrap;
      int n;
      boot(2'h3);
      for (int c = 0; c < 15; c++)
         sp(4'(c), {SCS_SPREAD_CENTER, 5'(c + 1), 5'(c + 1)});
      for (n = 0; n < 200 && wrap !== 1'b1; n++) @(posedge ref_clk);
      for (n = 1; n < 200; n++) begin
         @(posedge ref_clk);
         if (wrap === 1'b1) break;
      end
      chk(n, DIV * 4);
      // Clearing the modulation enable must flatten the deviation
      apb(1'b1, CTRL_OFS, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk(dev, 32'h0);
      chk(ratio, 16'(8 * RATIO_UNITY));
      apb(1'b1, CTRL_OFS, 32'h3);
      sp(SPREAD_CODE_OFF, {SCS_SPREAD_OFF, 10'h0});
   endtask : t_centre_wrap
   task automatic t_down;
      logic [1:0] rt [3] = '{2'h2, 2'h1, 2'h0};
      for (int i = 0; i < 3; i++) begin
         boot(rt[i]);
         sp(4'(4 * i + 3), {SCS_SPREAD_DOWN, 5'h0, 5'(8 * i + 8)});
         sp(4'(4 * i + 4), {SCS_SPREAD_ASYM, 5'h1, 5'(8 * i + 9)});
      end
   endtask : t_down
   task automatic t_enable;
      oe_in <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(soe, 1'b0);
      oe_in <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'(CTRL_RESET));
      chk(soe, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h2);
      repeat (2) @(posedge ref_clk);
      chk(soe, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0000_0000);
      apb(1'b1, CTRL_OFS, 32'h3);
   endtask : t_enable
   initial begin
      boot(2'h2);
      t_factor();
      t_enable();
      t_centre_wrap();
      t_down();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
